// File: include/modem_supervision_pkg.sv
// Behaviour
// - The alarm lamp lights on an alarm condition only in terminal use with alarm sensing on auto.
// - The alarm logic watches both receive carrier sensors, delayed carrier loss, transmit carrier loss and loss of receive and send data transitions.
// - The delayed carrier, receive transition and send transition alarms exist only in terminal use with the delayed-alarm option fitted.
// - In half-regenerator use the alarm logic is inhibited, but either supply rail failing still lights the lamp.
// - Lamp test lights the lamp on its own, whatever the alarm logic shows.
// - Line loop test loops receiver to transmitter on the line side and terminates the line pairs locally.
// - Digital loop test loops transmitter output back to receiver on the digital side.
// - A remote test request steps the unit through a fixed sequence of test states for the remote test center.
// - The test logic decides when the idle pattern replaces customer send data.
// - Only in half-regenerator use, the unit leaves the line on incompatible signals and rejoins on compatible data.
// - The receive pair is monitored all the time, bypassed or not, to judge compatibility.
// - The external clock output runs regardless of the local test jack.
// - Relay-switched loopback paths exist for the clock and data leads.
// - A bit-rate selector sets the interface clock rate.
// - The receive signal sensor reports compatible only with a compatible signal and the receiver in sync.
package modem_supervision_pkg;

	// ************************************************************
	// Timing.
	// ************************************************************
	localparam int CLK_HZ             = 100_000_000;
	localparam int ALARM_DELAY_US     = 40;
	localparam int ALARM_DELAY_CYCLES = ALARM_DELAY_US * (CLK_HZ / 1_000_000);
	localparam int TEST_STEP_US       = 40;
	localparam int TEST_STEP_CYCLES   = TEST_STEP_US * (CLK_HZ / 1_000_000);
	localparam int BIT_RATE_HZ        = 2400;
	localparam int BIT_DIV_BASE       = CLK_HZ / BIT_RATE_HZ;
	localparam int CNT_W              = 12;
	localparam int DIV_W              = 20;

	// ************************************************************
	// Register map.
	// ************************************************************
	localparam logic [7:0] ADDR_CTRL       = 8'h00;
	localparam logic [7:0] ADDR_STATUS     = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
	localparam logic [7:0] ADDR_IRQ_MASK   = 8'h0c;

	localparam int CTRL_W           = 10;
	localparam int CTRL_REGEN       = 0;
	localparam int CTRL_DELAY_OPT   = 1;
	localparam int CTRL_ALARM_AUTO  = 2;
	localparam int CTRL_LAMP_TEST   = 3;
	localparam int CTRL_LOOP_LINE   = 4;
	localparam int CTRL_LOOP_DIG    = 5;
	localparam int CTRL_RATE_LO     = 6;
	localparam int CTRL_REMOTE_EN   = 8;
	localparam int CTRL_FORCE_IDLE  = 9;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h004;

	localparam int IRQ_W          = 4;
	localparam int IRQ_ALARM      = 0;
	localparam int IRQ_BYPASS     = 1;
	localparam int IRQ_TEST_DONE  = 2;
	localparam int IRQ_RAIL_FAIL  = 3;

	// ************************************************************
	// Types.
	// ************************************************************
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_type;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_type;

	typedef struct packed {
		logic rx_carrier_loss_a;
		logic rx_carrier_loss_b;
		logic tx_carrier_loss;
		logic rx_data_transition_loss;
		logic tx_data_transition_loss;
	} sensor_type;

	typedef struct packed {
		logic line_loop;
		logic line_terminate;
		logic digital_loop;
		logic clock_loop_relay;
		logic data_loop_relay;
	} loop_type;

	typedef enum logic [2:0] {
		TEST_IDLE,
		TEST_IDLE_CODE,
		TEST_DIGITAL,
		TEST_LINE,
		TEST_DONE
	} test_state_type;

	typedef struct packed {
		logic [2:0][CNT_W-1:0] count;
		logic [2:0]            fired;
	} delay_state_type;

	typedef struct packed {
		logic [DIV_W-1:0] count;
		logic             tick;
		logic             clk_out;
	} divider_state_type;

	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic [IRQ_W-1:0]  irq_status;
		logic [IRQ_W-1:0]  irq_mask;
		logic [31:0]       rdata;
		logic              slverr;
		test_state_type    test;
		logic [CNT_W-1:0]  step;
		logic              online;
		logic              alarm_prev;
		logic              rail_prev;
		logic              lamp;
		loop_type          loops;
		logic              send_idle;
	} top_state_type;

endpackage

// File: rtl/alarm_delay.sv
`timescale 1ns/1ps
module alarm_delay (
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       enable,
	input  wire logic [2:0] cond,
	output logic      [2:0] fired
);

	modem_supervision_pkg::delay_state_type state_reg;
	modem_supervision_pkg::delay_state_type state_next;

	// ************************************************************
	// Each condition must persist for the full delay to fire.
	// ************************************************************
	always_comb begin
		state_next = state_reg;
		for (int i = 0; i < 3; i++) begin
			if (!enable || !cond[i]) begin
				state_next.count[i] = '0;
				state_next.fired[i] = 1'b0;
			end else if (state_reg.count[i] ==
				modem_supervision_pkg::CNT_W'(modem_supervision_pkg::ALARM_DELAY_CYCLES - 1)) begin
				state_next.fired[i] = 1'b1;
			end else begin
				state_next.count[i] = state_reg.count[i] + 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign fired = state_reg.fired;

endmodule // alarm_delay

// File: rtl/rate_divider.sv
`timescale 1ns/1ps
module rate_divider (
	input  wire logic                                    pclk,
	input  wire logic                                    presetn,
	input  wire logic [modem_supervision_pkg::DIV_W-1:0] divisor,
	output logic                                         tick,
	output logic                                         clk_out
);

	modem_supervision_pkg::divider_state_type state_reg;
	modem_supervision_pkg::divider_state_type state_next;

	// ************************************************************
	// Free-running divider; the clock output toggles each half period.
	// ************************************************************
	always_comb begin
		state_next      = state_reg;
		state_next.tick = 1'b0;
		if (state_reg.count >= divisor - 1'b1) begin
			state_next.count   = '0;
			state_next.tick    = 1'b1;
			state_next.clk_out = ~state_reg.clk_out;
		end else begin
			state_next.count = state_reg.count + 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign tick    = state_reg.tick;
	assign clk_out = state_reg.clk_out;

endmodule // rate_divider

// File: rtl/modem_alarm_test_bypass_control.sv
`timescale 1ns/1ps
module modem_alarm_test_bypass_control #(
	parameter int BIT_DIV = modem_supervision_pkg::BIT_DIV_BASE
) (
	input  wire logic                               pclk,
	input  wire logic                               presetn,
	input  wire modem_supervision_pkg::apb_req_type apb_req,
	output modem_supervision_pkg::apb_rsp_type      apb_rsp,
	input  wire modem_supervision_pkg::sensor_type  sensors,
	input  wire logic                               pos_rail_fail,
	input  wire logic                               neg_rail_fail,
	input  wire logic                               guard_band_ok,
	input  wire logic                               rx_in_sync,
	input  wire logic                               remote_test_request,
	output logic                                    alarm_lamp,
	output modem_supervision_pkg::loop_type         loops,
	output logic                                    idle_pattern,
	output logic                                    line_online,
	output logic                                    bit_tick,
	output logic                                    external_clock_out,
	output logic                                    irq
);

	modem_supervision_pkg::top_state_type state_reg;
	modem_supervision_pkg::top_state_type state_next;

	logic                                    regen;
	logic                                    terminal;
	logic                                    rx_compatible;
	logic [2:0]                              delayed_cond;
	logic [2:0]                              delayed_fired;
	logic                                    alarm_active;
	logic                                    rail_fail;
	logic                                    sel_line;
	logic                                    sel_digital;
	logic [1:0]                              rate_sel;
	logic [modem_supervision_pkg::DIV_W-1:0] divisor;
	logic                                    setup;
	logic                                    access;
	logic                                    mapped;
	logic [31:0]                             status_word;
	logic [31:0]                             read_word;
	logic [modem_supervision_pkg::IRQ_W-1:0] events;

	// ************************************************************
	// Mode decode and alarm logic.
	// ************************************************************
	assign regen    = state_reg.ctrl[modem_supervision_pkg::CTRL_REGEN];
	assign terminal = ~regen;

	// Both guard band and sync must hold; the sensor sees the pair while bypassed too.
	assign rx_compatible = guard_band_ok & rx_in_sync;

	assign delayed_cond = {sensors.tx_data_transition_loss,
		sensors.rx_data_transition_loss,
		sensors.rx_carrier_loss_a | sensors.rx_carrier_loss_b};

	alarm_delay u_alarm_delay (
		.pclk    (pclk),
		.presetn (presetn),
		.enable  (terminal & state_reg.ctrl[modem_supervision_pkg::CTRL_DELAY_OPT]),
		.cond    (delayed_cond),
		.fired   (delayed_fired)
	);

	// The inhibit in half-regenerator use masks every sensor.
	assign alarm_active = terminal & (sensors.rx_carrier_loss_a | sensors.rx_carrier_loss_b
		| sensors.tx_carrier_loss | (|delayed_fired));
	assign rail_fail = pos_rail_fail | neg_rail_fail;

	// ************************************************************
	// Loop selection and bit rate.
	// ************************************************************
	assign sel_line = state_reg.ctrl[modem_supervision_pkg::CTRL_LOOP_LINE]
		& ~state_reg.ctrl[modem_supervision_pkg::CTRL_LOOP_DIG];
	assign sel_digital = state_reg.ctrl[modem_supervision_pkg::CTRL_LOOP_DIG]
		& ~state_reg.ctrl[modem_supervision_pkg::CTRL_LOOP_LINE];

	assign rate_sel = state_reg.ctrl[modem_supervision_pkg::CTRL_RATE_LO +: 2];
	assign divisor  = modem_supervision_pkg::DIV_W'(BIT_DIV) << rate_sel;

	// Nothing gates the divider output, so the clock keeps running during local tests.
	rate_divider u_rate_divider (
		.pclk    (pclk),
		.presetn (presetn),
		.divisor (divisor),
		.tick    (bit_tick),
		.clk_out (external_clock_out)
	);

	// ************************************************************
	// Bus decode.
	// ************************************************************
	assign setup  = apb_req.psel & ~apb_req.penable;
	assign access = apb_req.psel & apb_req.penable;
	assign mapped = (apb_req.paddr == modem_supervision_pkg::ADDR_CTRL)
		| (apb_req.paddr == modem_supervision_pkg::ADDR_STATUS)
		| (apb_req.paddr == modem_supervision_pkg::ADDR_IRQ_STATUS)
		| (apb_req.paddr == modem_supervision_pkg::ADDR_IRQ_MASK);

	assign status_word = {22'h000000,
		state_reg.test != modem_supervision_pkg::TEST_IDLE,
		state_reg.send_idle,
		rail_fail,
		delayed_fired,
		rx_compatible,
		state_reg.online,
		state_reg.lamp,
		alarm_active};

	always_comb begin
		case (apb_req.paddr)
			modem_supervision_pkg::ADDR_CTRL: begin
				read_word = {22'h000000, state_reg.ctrl};
			end
			modem_supervision_pkg::ADDR_STATUS: begin
				read_word = status_word;
			end
			modem_supervision_pkg::ADDR_IRQ_STATUS: begin
				read_word = {28'h0000000, state_reg.irq_status};
			end
			modem_supervision_pkg::ADDR_IRQ_MASK: begin
				read_word = {28'h0000000, state_reg.irq_mask};
			end
			default: begin
				read_word = 32'h00000000;
			end
		endcase
	end

	// ************************************************************
	// Next state.
	// ************************************************************
	always_comb begin
		state_next = state_reg;
		events     = '0;

		if (setup) begin
			state_next.rdata  = apb_req.pwrite ? 32'h00000000 : read_word;
			state_next.slverr = ~mapped;
		end

		if (access && apb_req.pwrite) begin
			if (apb_req.paddr == modem_supervision_pkg::ADDR_CTRL) begin
				state_next.ctrl = apb_req.pwdata[modem_supervision_pkg::CTRL_W-1:0];
			end
			if (apb_req.paddr == modem_supervision_pkg::ADDR_IRQ_MASK) begin
				state_next.irq_mask = apb_req.pwdata[modem_supervision_pkg::IRQ_W-1:0];
			end
		end

		// Remote test sequence, one fixed step time each in the idle code, digital and line states.
		state_next.step = state_reg.step + 1'b1;
		if (state_reg.step ==
			modem_supervision_pkg::CNT_W'(modem_supervision_pkg::TEST_STEP_CYCLES - 1)) begin
			state_next.step = '0;
		end
		case (state_reg.test)
			modem_supervision_pkg::TEST_IDLE: begin
				state_next.step = '0;
				if (remote_test_request
					&& state_reg.ctrl[modem_supervision_pkg::CTRL_REMOTE_EN]) begin
					state_next.test = modem_supervision_pkg::TEST_IDLE_CODE;
				end
			end
			modem_supervision_pkg::TEST_IDLE_CODE: begin
				if (state_next.step == '0) begin
					state_next.test = modem_supervision_pkg::TEST_DIGITAL;
				end
			end
			modem_supervision_pkg::TEST_DIGITAL: begin
				if (state_next.step == '0) begin
					state_next.test = modem_supervision_pkg::TEST_LINE;
				end
			end
			modem_supervision_pkg::TEST_LINE: begin
				if (state_next.step == '0) begin
					state_next.test = modem_supervision_pkg::TEST_DONE;
				end
			end
			modem_supervision_pkg::TEST_DONE: begin
				state_next.test = modem_supervision_pkg::TEST_IDLE;
				events[modem_supervision_pkg::IRQ_TEST_DONE] = 1'b1;
			end
			default: begin
				state_next.test = modem_supervision_pkg::TEST_IDLE;
			end
		endcase

		// Loop relays from the switch or from the remote test.
		state_next.loops.line_loop = sel_line
			| (state_reg.test == modem_supervision_pkg::TEST_LINE);
		state_next.loops.line_terminate   = state_next.loops.line_loop;
		state_next.loops.digital_loop = sel_digital
			| (state_reg.test == modem_supervision_pkg::TEST_DIGITAL);
		state_next.loops.clock_loop_relay = state_next.loops.digital_loop;
		state_next.loops.data_loop_relay  = state_next.loops.digital_loop;

		state_next.send_idle = state_reg.ctrl[modem_supervision_pkg::CTRL_FORCE_IDLE]
			| (state_reg.test == modem_supervision_pkg::TEST_IDLE_CODE);

		// Bypass follows compatibility in regenerator use; a terminal stays on line.
		if (!regen) begin
			state_next.online = 1'b1;
		end else begin
			state_next.online = rx_compatible;
		end
		events[modem_supervision_pkg::IRQ_BYPASS] = state_next.online != state_reg.online;

		state_next.lamp = state_reg.ctrl[modem_supervision_pkg::CTRL_LAMP_TEST]
			| (alarm_active & state_reg.ctrl[modem_supervision_pkg::CTRL_ALARM_AUTO])
			| (regen & rail_fail);

		state_next.alarm_prev = alarm_active;
		state_next.rail_prev  = rail_fail;
		events[modem_supervision_pkg::IRQ_ALARM]     = alarm_active & ~state_reg.alarm_prev;
		events[modem_supervision_pkg::IRQ_RAIL_FAIL] = rail_fail & ~state_reg.rail_prev;

		// A read clears only the bits that it reported; a new event in that cycle survives.
		if (access && !apb_req.pwrite
			&& apb_req.paddr == modem_supervision_pkg::ADDR_IRQ_STATUS) begin
			state_next.irq_status = (state_reg.irq_status
				& ~state_reg.rdata[modem_supervision_pkg::IRQ_W-1:0]) | events;
		end else begin
			state_next.irq_status = state_reg.irq_status | events;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg      <= '0;
			state_reg.ctrl <= modem_supervision_pkg::CTRL_RESET;
			state_reg.test <= modem_supervision_pkg::TEST_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ************************************************************
	// Outputs.
	// ************************************************************
	assign apb_rsp.prdata  = state_reg.rdata;
	assign apb_rsp.pready  = 1'b1;
	assign apb_rsp.pslverr = access & state_reg.slverr;
	assign alarm_lamp      = state_reg.lamp;
	assign loops           = state_reg.loops;
	assign idle_pattern    = state_reg.send_idle;
	assign line_online     = state_reg.online;
	assign irq             = |(state_reg.irq_status & state_reg.irq_mask);

endmodule // modem_alarm_test_bypass_control

// File: testbench/modem_alarm_props.sv
`timescale 1ns/1ps
// ****
// Checker.
// ****
module modem_alarm_props #(
	parameter int BIT_DIV = 8
) (
	input wire logic                               pclk,
	input wire logic                               presetn,
	input wire modem_supervision_pkg::apb_req_type apb_req,
	input wire modem_supervision_pkg::apb_rsp_type apb_rsp,
	input wire modem_supervision_pkg::sensor_type  sensors,
	input wire logic                               pos_rail_fail,
	input wire logic                               neg_rail_fail,
	input wire logic                               guard_band_ok,
	input wire logic                               rx_in_sync,
	input wire logic                               remote_test_request,
	input wire logic                               alarm_lamp,
	input wire modem_supervision_pkg::loop_type    loops,
	input wire logic                               idle_pattern,
	input wire logic                               line_online,
	input wire logic                               bit_tick,
	input wire logic                               external_clock_out,
	input wire logic                               irq
);
	logic [9:0] cs;
	int         gap;
	wire        cmp  = guard_band_ok & rx_in_sync;
	wire        fail = pos_rail_fail | neg_rail_fail;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cs  <= 10'h004;
			gap <= BIT_DIV;
		end else begin
			if (apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.paddr == 8'h00)
				cs <= apb_req.pwdata[9:0];
			gap <= bit_tick ? 0 : gap + 1;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_bad; cs[0] && !cmp; endsequence
	sequence s_good; cs[0] && cmp; endsequence
	sequence s_code_end; cs[8] && idle_pattern && !cs[9] && !$past(cs[9]) ##1 !idle_pattern; endsequence

	property p_lamp_test; cs[3] |=> alarm_lamp; endproperty
	a_lamp_test: assert property (p_lamp_test) else $error("lamp test ignored");
	property p_rail; cs[0] && fail |=> alarm_lamp; endproperty
	a_rail: assert property (p_rail) else $error("rail fail not shown");
	property p_inhibit; cs[0] && !cs[3] && !fail |=> !alarm_lamp; endproperty
	a_inhibit: assert property (p_inhibit) else $error("alarm not inhibited");
	property p_alarm; !cs[0] && cs[2] && (sensors.rx_carrier_loss_a ||
		sensors.rx_carrier_loss_b || sensors.tx_carrier_loss) |=> alarm_lamp; endproperty
	a_alarm: assert property (p_alarm) else $error("alarm lamp missing");
	property p_manual; !cs[0] && !cs[2] && !cs[3] |=> !alarm_lamp; endproperty
	a_manual: assert property (p_manual) else $error("lamp lit while manual");
	property p_line; cs[4] && !cs[5] && !cs[8] |=>
		loops.line_loop && loops.line_terminate && !loops.digital_loop; endproperty
	a_line: assert property (p_line) else $error("line loop wrong");
	property p_dig; cs[5] && !cs[4] && !cs[8] |=> loops.digital_loop && !loops.line_loop; endproperty
	a_dig: assert property (p_dig) else $error("digital loop wrong");
	property p_none; cs[4] == cs[5] && !cs[8] |=> !loops.line_loop && !loops.digital_loop; endproperty
	a_none: assert property (p_none) else $error("loop without selection");
	property p_term; !cs[0] [*2] |=> line_online; endproperty
	a_term: assert property (p_term) else $error("terminal off line");
	property p_off; s_bad [*3] |=> !line_online; endproperty
	a_off: assert property (p_off) else $error("not bypassed");
	property p_on; s_good [*3] |=> line_online; endproperty
	a_on: assert property (p_on) else $error("not back on line");
	property p_tick; bit_tick |-> gap >= BIT_DIV - 1; endproperty
	a_tick: assert property (p_tick) else $error("tick too early");
	property p_clk; $changed(external_clock_out) |-> bit_tick || $past(bit_tick); endproperty
	a_clk: assert property (p_clk) else $error("clock moved off tick");
	property p_idle; cs[9] |=> idle_pattern; endproperty
	a_idle: assert property (p_idle) else $error("idle not forced");
	property p_step; s_code_end |-> ##[0:1] loops.digital_loop; endproperty
	a_step: assert property (p_step) else $error("no digital step");
endmodule // modem_alarm_props

bind modem_alarm_test_bypass_control modem_alarm_props #(.BIT_DIV(BIT_DIV)) u_props (
	.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.sensors(sensors), .pos_rail_fail(pos_rail_fail), .neg_rail_fail(neg_rail_fail),
	.guard_band_ok(guard_band_ok), .rx_in_sync(rx_in_sync),
	.remote_test_request(remote_test_request), .alarm_lamp(alarm_lamp), .loops(loops),
	.idle_pattern(idle_pattern), .line_online(line_online), .bit_tick(bit_tick),
	.external_clock_out(external_clock_out), .irq(irq)
);

// File: testbench/remote_center.sv
`timescale 1ns/1ps
// ****
// Far modem and test center.
// ****
module remote_center (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic want_compat,
	input  wire logic slow,
	input  wire logic go,
	input  wire logic idle_pattern,
	output logic      guard_band_ok,
	output logic      rx_in_sync,
	output logic      remote_test_request
);
	int lag;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			guard_band_ok       <= 1'b0;
			rx_in_sync          <= 1'b0;
			remote_test_request <= 1'b0;
			lag                 <= 0;
		end else begin
			guard_band_ok <= want_compat;
			lag           <= want_compat ? lag + 1 : 0;
			rx_in_sync    <= want_compat && (!slow || lag > 4);
			if (go)
				remote_test_request <= 1'b1;
			else if (idle_pattern)
				remote_test_request <= 1'b0;
		end
	end
endmodule // remote_center

// File: testbench/tb_modem_alarm_test_bypass_control.sv
`timescale 1ns/1ps
// ****
// Testbench.
// ****
module tb_modem_alarm_test_bypass_control;
	localparam int DIV = 8;
	localparam int T   = modem_supervision_pkg::TEST_STEP_CYCLES;
	modem_supervision_pkg::apb_req_type rq;
	modem_supervision_pkg::apb_rsp_type rs;
	modem_supervision_pkg::sensor_type  sn;
	modem_supervision_pkg::loop_type    lp;
	logic                               pclk, presetn, pf, nf, gb, sy, rtr, wc, slow, go;
	logic                               lamp, idle, onl, tick, xclk, irq, er;
	logic [31:0]                        rd;
	int                                 bad_count, total_checks, n, e;

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	modem_alarm_test_bypass_control #(.BIT_DIV(DIV)) u_dut (
		.pclk(pclk), .presetn(presetn), .apb_req(rq), .apb_rsp(rs), .sensors(sn),
		.pos_rail_fail(pf), .neg_rail_fail(nf), .guard_band_ok(gb), .rx_in_sync(sy),
		.remote_test_request(rtr), .alarm_lamp(lamp), .loops(lp), .idle_pattern(idle),
		.line_online(onl), .bit_tick(tick), .external_clock_out(xclk), .irq(irq)
	);

	remote_center u_far (
		.pclk(pclk), .presetn(presetn), .want_compat(wc), .slow(slow), .go(go),
		.idle_pattern(idle), .guard_band_ok(gb), .rx_in_sync(sy), .remote_test_request(rtr)
	);

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic ck(input logic [31:0] g, input logic [31:0] x, input string m);
		total_checks++;
		if (g !== x) begin
			bad_count++;
			$display("ERROR %0t %s got %h exp %h", $time, m, g, x);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		rq <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		rq.penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (rs.pready !== 1'b1 && k < 20);
		rd = rs.prdata;
		er = rs.pslverr;
		rq <= '0;
		if (k >= 20) begin
			ck(0, 1, "bus hang");
			end_sim();
		end
	endtask

	task automatic wt(input int c);
		repeat (c) @(posedge pclk);
	endtask

	function automatic logic sig(input int s);
		case (s)
			0: return idle;
			1: return lp.digital_loop;
			2: return lp.line_loop;
			3: return tick;
			default: return irq;
		endcase
	endfunction

	task automatic till(input int s, input logic v, output int c);
		c = 0;
		while (sig(s) !== v && c < 5000) begin
			@(posedge pclk);
			c++;
		end
		if (c >= 5000) begin
			ck(0, 1, "wait ran out");
			end_sim();
		end
	endtask

	initial begin
		#500000;
		ck(0, 1, "timeout");
		end_sim();
	end

	initial begin
		rq = '0;
		sn = '0;
		{pf, nf, wc, slow, go, presetn} = '0;
		bad_count = 0;
		total_checks = 0;
		n = $urandom(16444);
		wt(8);
		presetn <= 1'b1;
		apb(0, 8'h00, 0);
		ck(rd, 32'h004, "ctrl reset");
		apb(0, 8'h0c, 0);
		ck(rd, 0, "mask reset");
		apb(0, 8'h10, 0);
		ck(er, 1, "unmapped error");
		ck(rd, 0, "unmapped data");
		$display("reset test done");
		for (int i = 0; i < 32; i++) begin
			e = $urandom;
			apb(1, 8'h00, e & 32'h0d);
			sn <= e[8:4];
			pf <= e[9];
			nf <= e[10];
			wt(3);
			ck(lamp, e[3] | (!e[0] & e[2] & (e[8] | e[7] | e[6])) | (e[0] & (e[9] | e[10])),
				"lamp");
		end
		{pf, nf} <= 2'b00;
		apb(1, 8'h00, 32'h004);
		sn <= 5'h02;
		wt(4100);
		ck(lamp, 0, "no option");
		apb(1, 8'h00, 32'h006);
		wt(3990);
		ck(lamp, 0, "early");
		wt(20);
		ck(lamp, 1, "delayed");
		apb(0, 8'h04, 0);
		ck(rd, 32'h00000027, "status");
		sn <= '0;
		wt(3);
		ck(lamp, 0, "cleared");
		$display("lamp test done");
		for (int k = 0; k < 4; k++) begin
			apb(1, 8'h00, 32'h004 | (k << 4));
			wt(2);
			ck({lp.line_loop, lp.line_terminate, lp.digital_loop, lp.clock_loop_relay,
				lp.data_loop_relay}, {k == 1, k == 1, k == 2, k == 2, k == 2},
				"loops");
		end
		$display("loop test done");
		apb(1, 8'h0c, 32'h2);
		apb(1, 8'h00, 32'h005);
		wt(4);
		apb(0, 8'h08, 0);
		e = 0;
		for (int i = 0; i < 8; i++) begin
			n = $urandom;
			wc <= n[0];
			slow <= n[1];
			wt(12);
			ck(onl, n[0], "online");
			ck(irq, n[0] != e[0], "irq");
			apb(0, 8'h08, 0);
			ck(rd[1], n[0] != e[0], "event");
			wt(2);
			ck(irq, 0, "irq clear");
			e = n[0];
		end
		apb(1, 8'h0c, 0);
		wc <= ~wc;
		wt(12);
		ck(irq, 0, "masked");
		apb(0, 8'h08, 0);
		ck(rd[1], 1, "masked event");
		$display("bypass test done");
		apb(1, 8'h00, 32'h104);
		apb(1, 8'h0c, 32'h4);
		apb(0, 8'h08, 0);
		go <= 1'b1;
		wt(1);
		go <= 1'b0;
		till(0, 1, n);
		ck(n < 20, 1, "test start");
		till(0, 0, n);
		ck((n - T) * (n - T) <= 1, 1, "idle step");
		ck(lp.digital_loop, 1, "digital step");
		till(1, 0, n);
		ck((n - T) * (n - T) <= 1, 1, "digital length");
		ck(lp.line_loop, 1, "line step");
		till(2, 0, n);
		ck((n - T) * (n - T) <= 1, 1, "line length");
		till(4, 1, n);
		ck(n < 5, 1, "done irq");
		apb(0, 8'h08, 0);
		ck(rd[2], 1, "done event");
		apb(1, 8'h00, 32'h004);
		$display("remote test done");
		for (int k = 0; k < 4; k++) begin
			apb(1, 8'h00, 32'h004 | (k << 6));
			till(3, 1, n);
			wt(1);
			till(3, 1, n);
			e = xclk;
			wt(1);
			till(3, 1, n);
			ck(n + 1, DIV << k, "tick period");
			ck(xclk, !e[0], "clock toggle");
		end
		for (int k = 0; k < 2; k++) begin
			apb(1, 8'h00, 32'h004 | (k << 9));
			wt(2);
			ck(idle, k & 1, "forced idle");
		end
		$display("clock and idle test done");
		end_sim();
	end
endmodule // tb_modem_alarm_test_bypass_control
